// *** include/ccf_pkg.sv ***
// package for the counter-clear, memory-command and temperature register block
// assumes a byte-wide register port driven by the serial link decoder outside
package ccf_pkg;
    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] ADDR_TEMPERATURE_LOW = 8'h60;
    localparam logic [7:0] ADDR_TEMPERATURE_HIGH = 8'h61;
    localparam logic [7:0] ADDR_MEMORY_COMMAND = 8'h62;
    localparam logic [7:0] ADDR_COUNTER_CLEAR = 8'h63;
    localparam logic [7:0] ADDR_PROGRAM_DATA = 8'h6f;
    localparam logic [7:0] ADDR_PROGRAM_ADDRESS = 8'h70;
    localparam logic [7:0] ADDR_SHADOW_FIRST = 8'h75;

    // ****************************************
    // counter clear control fields and register reset values
    // ****************************************
    localparam int CLR_DISCHARGE_BIT = 0;
    localparam int CLR_CHARGE_BIT = 1;
    localparam int CLR_SELF_BIT = 2;
    localparam int CLR_DTIME_BIT = 3;
    localparam int CLR_CTIME_BIT = 4;
    localparam int CLR_PIN_BIT = 5;
    localparam int CLR_POR_BIT = 6;
    localparam int CLR_RESERVED_TOP_BIT_BIT = 7;
    localparam logic [7:0] CLR_RESET = 8'h60;
    localparam logic [7:0] TEMP_HIGH_RESET = 8'h00;
    localparam logic [2:0] SLEEP_SEL_RESET = 3'h7;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_PROGRAM = 8'h0f;
    localparam logic [7:0] CMD_ERASE_P0 = 8'h40;
    localparam logic [7:0] CMD_ERASE_P1 = 8'h41;
    localparam logic [7:0] CMD_ERASE_P2 = 8'h42;
    localparam logic [7:0] CMD_ERASE_SHADOW = 8'h43;
    localparam logic [7:0] CMD_RAM_TO_FLASH = 8'h45;
    localparam logic [7:0] CMD_FLASH_TO_RAM = 8'h48;
    localparam logic [7:0] CMD_POWER_DOWN = 8'hf6;
    localparam logic [7:0] CMD_CAL_POWER_DOWN = 8'hf7;

    // ****************************************
    // memory geometry and timing
    // ****************************************
    localparam int FLASH_BYTES = 99;
    localparam int PAGE_BYTES = 32;
    localparam logic [6:0] SHADOW_BASE = 7'h60;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int CAL_TIME_NS = 1000;
    localparam int CLOCK_NS = 20;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam logic [5:0] CAL_COUNT = 6'(CAL_CYCLES);

    typedef enum logic [2:0] {
        CCF_IDLE = 3'b000,
        CCF_WALK = 3'b001,
        CCF_WAIT_SENSE = 3'b010,
        CCF_CALIBRATE = 3'b011,
        CCF_SLEEP = 3'b100
    } ccf_state_t;
endpackage

// *** design/ccf_temp_reg.sv ***
// temperature register pair: 9-bit kelvin value split over two bytes
// assumes the sensor value arrives synchronous to clock
`timescale 1ns/10ps
`default_nettype none
module ccf_temp_reg
    import ccf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [8:0] sensor_kelvin,
    input wire logic high_wr,
    input wire logic [7:0] wr_data,
    output logic [7:0] temperature_low,
    output logic [7:0] temperature_high
);
    // ****************************************
    // sampling
    // ****************************************
    // low byte tracks the sensor every clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            temperature_low <= 8'h00;
        end else begin
            temperature_low <= sensor_kelvin[7:0];
        end
    end

    // upper bits are storage the host is told to zero; bit 0 is the sensor msb
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            temperature_high <= TEMP_HIGH_RESET;
        end else if (high_wr) begin
            temperature_high <= {wr_data[7:1], sensor_kelvin[8]};
        end else begin
            temperature_high <= {temperature_high[7:1], sensor_kelvin[8]};
        end
    end
endmodule
`default_nettype wire

// *** design/ccf_regs.sv ***
// counter clear, memory command and temperature registers of the monitor
// assumes a synchronous byte register port from the link decoder and a
// one-cycle pulse from the link receiver on every line transition
`timescale 1ns/10ps
`default_nettype none
module ccf_regs
    import ccf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic line_toggle,
    input wire logic [2:0] sleep_threshold_select,
    input wire logic sense_below,
    input wire logic [8:0] sensor_kelvin,
    input wire logic [7:0] ram_rd_data,
    output logic ram_wr,
    output logic [4:0] ram_addr,
    output logic [7:0] ram_wr_data,
    output logic clear_charge_time_counter,
    output logic clear_discharge_time_counter,
    output logic clear_self_discharge_counter,
    output logic clear_charge_counter,
    output logic clear_discharge_counter,
    output logic status_pin_out,
    output logic status_pin_oe,
    output logic sleeping,
    output logic calibrating
);
    // ****************************************
    // storage and decode
    // ****************************************
    logic [7:0] counter_clear_control;
    logic [7:0] memory_command;
    logic [7:0] program_address;
    logic [7:0] program_data;
    logic [7:0] temperature_low;
    logic [7:0] temperature_high;
    // pages 0 to 2 fill indices 0x00 to 0x5f; 0x60 to 0x62 hold the offset-control shadow bytes
    logic [7:0] flash_mem [0:FLASH_BYTES-1];
    ccf_state_t state;
    logic [6:0] walk_idx;
    logic [5:0] cal_count;
    logic walk_last;
    logic [6:0] flash_idx;
    logic [6:0] walk_base;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // sleep is allowed with any sense level when every select bit is clear
    function automatic logic sleep_ok(input logic [2:0] sel, input logic below);
        sleep_ok = (sel == 3'h0) || below;
    endfunction

    // ****************************************
    // temperature pair
    // ****************************************
    // only the high byte takes host writes; the low byte follows the sensor
    ccf_temp_reg u_temp (
        .clock(clock),
        .rst_n(rst_n),
        .sensor_kelvin(sensor_kelvin),
        .high_wr(reg_wr && hit(reg_addr, ADDR_TEMPERATURE_HIGH)),
        .wr_data(reg_wr_data),
        .temperature_low(temperature_low),
        .temperature_high(temperature_high)
    );

    // ****************************************
    // clear register
    // ****************************************
    // clear bits self-clear after one cycle so the counters see a pulse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            counter_clear_control <= CLR_RESET;
        end else if (reg_wr && hit(reg_addr, ADDR_COUNTER_CLEAR)) begin
            // the reserved bit is stored as written; keeping it intact is up to the host
            counter_clear_control <= reg_wr_data;
        end else begin
            counter_clear_control[4:0] <= 5'h00;
        end
    end

    assign clear_charge_time_counter = counter_clear_control[CLR_CTIME_BIT];
    assign clear_discharge_time_counter = counter_clear_control[CLR_DTIME_BIT];
    assign clear_self_discharge_counter = counter_clear_control[CLR_SELF_BIT];
    assign clear_charge_counter = counter_clear_control[CLR_CHARGE_BIT];
    assign clear_discharge_counter = counter_clear_control[CLR_DISCHARGE_BIT];
    // open drain: only ever drives low
    // the enable comes straight from the flop, so the pin does not glitch on decode
    assign status_pin_out = 1'b0;
    assign status_pin_oe = ~counter_clear_control[CLR_PIN_BIT];

    // ****************************************
    // program address and data
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            program_address <= 8'h00;
            program_data <= 8'h00;
        end else if (reg_wr) begin
            if (hit(reg_addr, ADDR_PROGRAM_ADDRESS)) begin
                program_address <= reg_wr_data;
            end
            if (hit(reg_addr, ADDR_PROGRAM_DATA)) begin
                program_data <= reg_wr_data;
            end
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************
    // range walks take one byte per clock; base and length depend on the code
    // shadow erase walks three bytes from its base, every other walk a full page
    always_comb begin
        walk_base = 7'h00;
        walk_last = 1'b0;
        case (memory_command)
            CMD_ERASE_P1: begin
                walk_base = 7'h20;
            end
            CMD_ERASE_P2: begin
                walk_base = 7'h40;
            end
            CMD_ERASE_SHADOW: begin
                walk_base = SHADOW_BASE;
            end
            default: begin
                walk_base = 7'h00;
            end
        endcase
        if (memory_command == CMD_ERASE_SHADOW) begin
            walk_last = (walk_idx == 7'd2);
        end else begin
            walk_last = (walk_idx == 7'(PAGE_BYTES - 1));
        end
        flash_idx = 7'(walk_base + walk_idx);
    end

    // a new code is only accepted while idle; the host polls for zero first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= CCF_IDLE;
            memory_command <= CMD_NONE;
            walk_idx <= 7'h00;
            cal_count <= 6'h00;
        end else begin
            case (state)
                CCF_IDLE: begin
                    walk_idx <= 7'h00;
                    if (reg_wr && hit(reg_addr, ADDR_MEMORY_COMMAND)) begin
                        memory_command <= reg_wr_data;
                        case (reg_wr_data)
                            CMD_PROGRAM, CMD_ERASE_P0, CMD_ERASE_P1, CMD_ERASE_P2, CMD_ERASE_SHADOW,
                            CMD_RAM_TO_FLASH, CMD_FLASH_TO_RAM: begin
                                state <= CCF_WALK;
                            end
                            CMD_POWER_DOWN, CMD_CAL_POWER_DOWN: begin
                                state <= CCF_WAIT_SENSE;
                            end
                            default: begin
                                // unknown codes are dropped so the host poll still sees zero
                                memory_command <= CMD_NONE;
                            end
                        endcase
                    end
                end
                CCF_WALK: begin
                    // program takes one cycle; the walks stop on the last index of their range
                    walk_idx <= 7'(walk_idx + 7'd1);
                    if (memory_command == CMD_PROGRAM || walk_last) begin
                        state <= CCF_IDLE;
                        memory_command <= CMD_NONE;
                    end
                end
                CCF_WAIT_SENSE: begin
                    // a line transition while waiting for the sense level cancels only calibrated power-down; plain power-down keeps waiting
                    if (memory_command == CMD_CAL_POWER_DOWN) begin
                        if (line_toggle) begin
                            state <= CCF_IDLE;
                            memory_command <= CMD_NONE;
                        end else if (sense_below) begin
                            state <= CCF_CALIBRATE;
                            cal_count <= CAL_COUNT;
                        end
                    end else if (sleep_ok(sleep_threshold_select, sense_below)) begin
                        state <= CCF_SLEEP;
                    end
                end
                CCF_CALIBRATE: begin
                    cal_count <= 6'(cal_count - 6'd1);
                    if (line_toggle) begin
                        state <= CCF_IDLE;
                        memory_command <= CMD_NONE;
                    end else if (cal_count == 6'd1) begin
                        state <= sleep_ok(sleep_threshold_select, sense_below) ? CCF_SLEEP : CCF_WAIT_SENSE;
                        // reuse the power-down path so the sleep select still gates sleep after calibrating
                        memory_command <= CMD_POWER_DOWN;
                    end
                end
                CCF_SLEEP: begin
                    if (line_toggle) begin
                        // the link receiver turns either edge of the line into one pulse
                        state <= CCF_IDLE;
                        memory_command <= CMD_NONE;
                    end
                end
                default: begin
                    state <= CCF_IDLE;
                    memory_command <= CMD_NONE;
                end
            endcase
        end
    end

    // ****************************************
    // flash array
    // ****************************************
    // no reset on the array: it models nonvolatile contents
    always_ff @(posedge clock) begin
        if (state == CCF_WALK) begin
            case (memory_command)
                CMD_PROGRAM: begin
                    // an address beyond the array is dropped rather than wrapped onto another byte
                    if (program_address < 8'(FLASH_BYTES)) begin
                        flash_mem[program_address[6:0]] <= flash_mem[program_address[6:0]] & program_data;
                    end
                end
                CMD_ERASE_P0, CMD_ERASE_P1, CMD_ERASE_P2, CMD_ERASE_SHADOW: begin
                    flash_mem[flash_idx] <= ERASED_BYTE;
                end
                CMD_RAM_TO_FLASH: begin
                    flash_mem[walk_idx] <= ram_rd_data;
                end
                default: begin
                end
            endcase
        end
    end

    // ram port: address follows the walk, read data is combinational
    // limitation: the ram must answer in the same cycle, since a walk never stalls
    assign ram_addr = walk_idx[4:0];
    assign ram_wr = (state == CCF_WALK) && (memory_command == CMD_FLASH_TO_RAM);
    assign ram_wr_data = flash_mem[walk_idx];
    assign sleeping = (state == CCF_SLEEP);
    assign calibrating = (state == CCF_CALIBRATE);

    // ****************************************
    // read back
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd) begin
            // clear bits read as zero once their pulse is over; unmapped addresses read zero
            case (reg_addr)
                ADDR_TEMPERATURE_LOW: reg_rd_data <= temperature_low;
                ADDR_TEMPERATURE_HIGH: reg_rd_data <= temperature_high;
                ADDR_MEMORY_COMMAND: reg_rd_data <= memory_command;
                ADDR_COUNTER_CLEAR: reg_rd_data <= counter_clear_control;
                ADDR_PROGRAM_ADDRESS: reg_rd_data <= program_address;
                ADDR_PROGRAM_DATA: reg_rd_data <= program_data;
                default: reg_rd_data <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** tb/ccf_ram_model.sv ***
// partner model: the general-purpose ram that sits beside the register block
// assumes the block owns the ram port alone during its page walks
`timescale 1ns/10ps
`default_nettype none
module ccf_ram_model (
    input wire logic clock,
    input wire logic ram_wr,
    input wire logic [4:0] ram_addr,
    input wire logic [7:0] ram_wr_data,
    output logic [7:0] ram_rd_data
);
    // the bench preloads and inspects mem directly, so plain always is used
    logic [7:0] mem [32];
    assign ram_rd_data = mem[ram_addr]; // read is combinational for the walk
    always @(posedge clock) begin
        if (ram_wr) begin
            mem[ram_addr] <= ram_wr_data;
        end
    end
endmodule
`default_nettype wire

// *** tb/ccf_regs_asserts.sv ***
// checker for the register block, seeing only its ports
// assumes it is bound to every instance of the register block
`timescale 1ns/10ps
`default_nettype none
module ccf_regs_asserts
    import ccf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic line_toggle,
    input wire logic sense_below,
    input wire logic [8:0] sensor_kelvin,
    input wire logic clear_charge_time_counter,
    input wire logic clear_discharge_time_counter,
    input wire logic clear_self_discharge_counter,
    input wire logic clear_charge_counter,
    input wire logic clear_discharge_counter,
    input wire logic status_pin_oe,
    input wire logic sleeping,
    input wire logic calibrating
);
    // ****************************************
    // properties
    // ****************************************
    logic [4:0] clears;
    assign clears = {clear_charge_time_counter, clear_discharge_time_counter, clear_self_discharge_counter,
        clear_charge_counter, clear_discharge_counter};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_clr_wr;
        reg_wr && reg_addr == ADDR_COUNTER_CLEAR;
    endsequence
    sequence s_clr_settle;
        s_clr_wr ##1 !(reg_wr && reg_addr == ADDR_COUNTER_CLEAR);
    endsequence
    property p_clear_pulse;
        s_clr_wr |=> clears == $past(reg_wr_data[4:0]);
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulses do not match written bits");
    property p_clear_idle;
        !(reg_wr && reg_addr == ADDR_COUNTER_CLEAR) |=> clears == 5'h00;
    endproperty
    a_clear_idle: assert property (p_clear_idle) else $error("clear pulse without a clear write");
    property p_pin_level;
        s_clr_settle |=> status_pin_oe == !$past(reg_wr_data[5], 2);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("status pin drive differs from pin bit");
    property p_temp_low;
        reg_rd && reg_addr == ADDR_TEMPERATURE_LOW && $stable(sensor_kelvin) |=> reg_rd_data == $past(sensor_kelvin[7:0]);
    endproperty
    a_temp_low: assert property (p_temp_low) else $error("low temperature byte wrong");
    property p_temp_high;
        reg_rd && reg_addr == ADDR_TEMPERATURE_HIGH && $stable(sensor_kelvin) |=> reg_rd_data[0] == $past(sensor_kelvin[8]);
    endproperty
    a_temp_high: assert property (p_temp_high) else $error("temperature top bit wrong");
    property p_wake;
        sleeping && line_toggle |=> !sleeping;
    endproperty
    a_wake: assert property (p_wake) else $error("line transition did not end sleep");
    property p_sleep_hold;
        sleeping && !line_toggle |=> sleeping;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without a line transition");
    property p_cal_abort;
        calibrating && line_toggle |=> !calibrating && !sleeping;
    endproperty
    a_cal_abort: assert property (p_cal_abort) else $error("toggle during calibration not honoured");
    property p_cal_start;
        $rose(calibrating) |-> $past(sense_below);
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration began above threshold");
endmodule
bind ccf_regs ccf_regs_asserts chk_u (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .line_toggle(line_toggle),
    .sense_below(sense_below), .sensor_kelvin(sensor_kelvin), .clear_charge_time_counter(clear_charge_time_counter),
    .clear_discharge_time_counter(clear_discharge_time_counter), .clear_charge_counter(clear_charge_counter),
    .clear_self_discharge_counter(clear_self_discharge_counter), .clear_discharge_counter(clear_discharge_counter),
    .status_pin_oe(status_pin_oe), .sleeping(sleeping), .calibrating(calibrating));
`default_nettype wire

// *** tb/ccf_regs_test.sv ***
// self-checking bench for the register block with the ram partner beside it
// assumes the package constants and a 50 MHz clock
`timescale 1ns/10ps
`default_nettype none
module ccf_regs_test
    import ccf_pkg::*;
;
    logic clock, rst_n, reg_wr, reg_rd, line_toggle, sense_below, ram_wr, status_pin_out, status_pin_oe;
    logic sleeping, calibrating, c_ct, c_dt, c_sd, c_ch, c_dc;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, ram_rd_data, ram_wr_data, rv;
    logic [2:0] sleep_threshold_select;
    logic [8:0] sensor_kelvin;
    logic [4:0] ram_addr;
    int error_cnt = 0;
    int checked = 0;
    ccf_regs dut_u (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .line_toggle(line_toggle),
        .sleep_threshold_select(sleep_threshold_select), .sense_below(sense_below), .sensor_kelvin(sensor_kelvin),
        .ram_rd_data(ram_rd_data), .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wr_data(ram_wr_data),
        .clear_charge_time_counter(c_ct), .clear_discharge_time_counter(c_dt), .clear_self_discharge_counter(c_sd),
        .clear_charge_counter(c_ch), .clear_discharge_counter(c_dc), .status_pin_out(status_pin_out),
        .status_pin_oe(status_pin_oe), .sleeping(sleeping), .calibrating(calibrating));
    ccf_ram_model ram_u (.clock(clock), .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wr_data(ram_wr_data),
        .ram_rd_data(ram_rd_data));
    // ****************************************
    // bus tasks and compare
    // ****************************************
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        {reg_wr, reg_addr, reg_wr_data} = {1'b1, a, d};
        cyc(1);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a);
        cyc(1);
        {reg_rd, reg_addr} = {1'b1, a};
        cyc(1);
        reg_rd = 1'b0;
        rv = reg_rd_data;
    endtask
    task tog;
        cyc(1);
        line_toggle = 1'b1;
        cyc(1);
        line_toggle = 1'b0;
    endtask
    // host side waits for the command register to drop before moving on
    task cmd(input logic [7:0] c);
        wr(ADDR_MEMORY_COMMAND, c);
        for (int n = 0; n < 100; n++) begin
            rd(ADDR_MEMORY_COMMAND);
            if (rv === CMD_NONE) break;
        end
        chk(rv, CMD_NONE);
    endtask
    function automatic logic [7:0] pat(input int k);
        return 8'(k * 7) ^ 8'h5a;
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        rd(ADDR_COUNTER_CLEAR);
        chk(rv, CLR_RESET);
        rd(ADDR_TEMPERATURE_HIGH);
        chk({1'b0, rv[7:1]}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_COUNTER_CLEAR, 8'h60 | (8'h01 << i)); // top bit kept as read
            chk({3'h0, c_ct, c_dt, c_sd, c_ch, c_dc}, 8'h01 << i);
        end
        rd(ADDR_COUNTER_CLEAR);
        chk(rv, 8'h60);
        wr(ADDR_COUNTER_CLEAR, 8'h00);
        cyc(2);
        chk({status_pin_out, status_pin_oe}, 8'h01);
        rd(ADDR_COUNTER_CLEAR);
        chk(rv, 8'h00);
        wr(ADDR_COUNTER_CLEAR, 8'h60);
        cyc(2);
        chk({7'h0, status_pin_oe}, 8'h00);
        rd(ADDR_COUNTER_CLEAR);
        chk(rv, CLR_RESET);
        sensor_kelvin = 9'h1a5;
        cyc(3);
        wr(ADDR_TEMPERATURE_HIGH, 8'h00);
        rd(ADDR_TEMPERATURE_LOW);
        chk(rv, 8'ha5);
        rd(ADDR_TEMPERATURE_HIGH);
        chk(rv & 8'h01, 8'h01);
        wr(ADDR_PROGRAM_ADDRESS, 8'h05);
        wr(ADDR_PROGRAM_DATA, 8'h3c);
        rd(ADDR_PROGRAM_ADDRESS);
        chk(rv, 8'h05);
        rd(ADDR_PROGRAM_DATA);
        chk(rv, 8'h3c);
    endtask
    task t_flash;
        cmd(CMD_ERASE_P0);
        for (int i = 0; i < 32; i++) ram_u.mem[i] = pat(i);
        cmd(CMD_RAM_TO_FLASH);
        cmd(CMD_ERASE_P1);
        cmd(CMD_ERASE_P2);
        cmd(CMD_ERASE_SHADOW);
        for (int i = PAGE_BYTES; i < FLASH_BYTES; i++) chk(dut_u.flash_mem[i], ERASED_BYTE);
        cmd(CMD_PROGRAM);
        for (int i = 0; i < 32; i++) ram_u.mem[i] = 8'h00;
        cmd(CMD_FLASH_TO_RAM);
        for (int i = 0; i < 32; i++) chk(ram_u.mem[i], (i == 5) ? (pat(i) & 8'h3c) : pat(i));
        cmd(CMD_ERASE_P0);
        cmd(CMD_FLASH_TO_RAM);
        for (int i = 0; i < 32; i++) chk(ram_u.mem[i], ERASED_BYTE);
    endtask
    task t_sleep;
        {sleep_threshold_select, sense_below} = {3'h0, 1'b0};
        wr(ADDR_MEMORY_COMMAND, CMD_POWER_DOWN);
        cyc(25);
        chk({7'h0, sleeping}, 8'h01);
        tog;
        cyc(2);
        chk({7'h0, sleeping}, 8'h00);
        sleep_threshold_select = 3'h7;
        cmd(CMD_NONE);
        wr(ADDR_MEMORY_COMMAND, CMD_POWER_DOWN);
        cyc(20);
        chk({7'h0, sleeping}, 8'h00);
        sense_below = 1'b1;
        cyc(5);
        chk({7'h0, sleeping}, 8'h01);
        tog;
        sense_below = 1'b0;
        wr(ADDR_MEMORY_COMMAND, CMD_CAL_POWER_DOWN);
        cyc(10);
        chk({7'h0, calibrating}, 8'h00);
        tog;
        sense_below = 1'b1;
        cyc(CAL_CYCLES + 10);
        chk({6'h0, calibrating, sleeping}, 8'h00);
        wr(ADDR_MEMORY_COMMAND, CMD_CAL_POWER_DOWN);
        cyc(5);
        chk({7'h0, calibrating}, 8'h01);
        tog;
        cyc(CAL_CYCLES + 10);
        chk({6'h0, calibrating, sleeping}, 8'h00);
        cmd(CMD_NONE);
        wr(ADDR_MEMORY_COMMAND, CMD_CAL_POWER_DOWN); // last link transaction before sleep
        cyc(CAL_CYCLES - 10);
        chk({7'h0, calibrating}, 8'h01);
        cyc(20);
        chk({6'h0, calibrating, sleeping}, 8'h01);
        tog;
    endtask
    task results;
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // clock, reset, sequence and watchdog
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, line_toggle, sense_below, reg_addr, reg_wr_data} = '0;
        {sleep_threshold_select, sensor_kelvin} = {3'h7, 9'h000};
        cyc(4);
        rst_n = 1'b1;
        t_regs;
        t_flash;
        t_sleep;
        results;
    end
    // generous bound: the whole sequence needs well under 5000 cycles
    initial begin
        #400000;
        error_cnt++;
        results;
    end
endmodule
`default_nettype wire
